// >>> wsg_defines.svh
// register offsets, field positions, reset values and timing figures of the
// watchdog / safe-monitor pin block; assumes a 25 MHz system clock
`ifndef WSG_DEFINES_SVH
`define WSG_DEFINES_SVH

`define WSG_CLK_MHZ        25
`define WSG_TICK_US        256
`define WSG_TICK_CYC       (`WSG_TICK_US * `WSG_CLK_MHZ)
`define WSG_PULSE_MS       100
`define WSG_PULSE_CYC      (`WSG_PULSE_MS * 1000 * `WSG_CLK_MHZ)

`define WSG_ADR_CTRL       8'h00
`define WSG_ADR_WDCFG      8'h04
`define WSG_ADR_KEY        8'h08
`define WSG_ADR_STATUS     8'h0c
`define WSG_ADR_ALERT      8'h10
`define WSG_ADR_PIN1       8'h14
`define WSG_ADR_PIN4       8'h20
`define WSG_ADR_PINSTAT    8'h24

`define WSG_CTRL_EN        0
`define WSG_CTRL_SWW       1
`define WSG_CTRL_ALRTEN    2
`define WSG_CTRL_C12ALRT   3
`define WSG_CTRL_TOPO_LSB  4
`define WSG_CFG_DIV_LSB    0
`define WSG_CFG_CLOSED_LSB 8
`define WSG_CFG_OPEN_LSB   12
`define WSG_CFG_LIMIT_LSB  16
`define WSG_CFG_EXT_LSB    24

`define WSG_CTRL_RST       32'h0000_0024
`define WSG_WDCFG_RST      32'h0001_0000
`define WSG_KEY_RST        8'h5a
`define WSG_RESP_OKAY      2'b00
`define WSG_RESP_SLVERR    2'b10

`endif

// >>> wsg_pkg.sv
// types shared by the watchdog / safe-monitor pin block
// assumes wsg_defines.svh is not needed here: types only
package wsg_pkg;

   typedef enum logic [2:0] {
      WSG_PIN_INPUT,
      WSG_PIN_HI,
      WSG_PIN_LO,
      WSG_PIN_SHOT_HI,
      WSG_PIN_SHOT_LO,
      WSG_PIN_ACT_HI,
      WSG_PIN_ACT_LO,
      WSG_PIN_SLAVE_IN
   } wsg_pin_mode_t;

   typedef enum logic [1:0] {
      WSG_WD_OFF,
      WSG_WD_FIRST,
      WSG_WD_CLOSED,
      WSG_WD_OPEN
   } wsg_wd_state_t;

endpackage

// >>> wsg_tick_if.sv
// link between the watchdog core and its tick generator
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface wsg_tick_if;
   logic       run;
   logic [4:0] tick_divider;
   logic       tick;
   modport gen  (input run, input tick_divider, output tick);
   modport core (output run, output tick_divider, input tick);
endinterface

// >>> wsg_ticker.sv
// watchdog tick generator: base period of TICK_CYC clocks, divided by tick_divider+1
// assumes run drops whenever the watchdog is off so the phase restarts cleanly
`timescale 1ns/1ps
module wsg_ticker
   import wsg_pkg::*;
#(
   parameter int TICK_CYC = 6400
) (
   input wire logic  clk_sys,
   input wire logic  rst,
   wsg_tick_if.gen   tk
);

   logic [15:0] base_cnt;
   logic [4:0]  div_cnt;
   logic        tick;
   logic [15:0] next_base_cnt;
   logic [4:0]  next_div_cnt;
   logic        next_tick;

   assign tk.tick = tick;

   always_comb begin
      next_base_cnt = base_cnt;
      next_div_cnt  = div_cnt;
      next_tick     = 1'b0;
      if (!tk.run) begin
         next_base_cnt = 16'h0000;
         next_div_cnt  = 5'h00;
      end else if (base_cnt == 16'(TICK_CYC - 1)) begin
         next_base_cnt = 16'h0000;
         if (div_cnt >= tk.tick_divider) begin  // RULE_21
            next_div_cnt = 5'h00;
            next_tick    = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 5'h01;
         end
      end else begin
         next_base_cnt = base_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         base_cnt <= 16'h0000;
         div_cnt  <= 5'h00;
         tick     <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         div_cnt  <= next_div_cnt;
         tick     <= next_tick;
      end
   end

endmodule // wsg_ticker

// >>> wsg_top.sv
// windowed watchdog with refresh key, safe-monitor mode and four reacting pins,
// registers on an AXI4-Lite slave
// assumes pin inputs and sleep_mode are synchronous to clk_sys
`timescale 1ns/1ps
`include "wsg_defines.svh"

// Function
// (RULE_01) missed open window: timeout, count one violation
// (RULE_02) timeout sets expired flag until disable
// (RULE_03) count equals limit sets limit flag
// (RULE_04) enabled alert: errors set flag, interrupt
// (RULE_05) interrupt holds until alert flag cleared
// (RULE_06) four watchdog error flags feed alert
// (RULE_07) challenge mode accepts only next LFSR key
// (RULE_08) key register always reads current key
// (RULE_09) simple mode: any key write refreshes; code refreshes only in the first or open window
// (RULE_10) per-pin mode registers, pin-specific mode sets
// (RULE_11) one-shot modes give single 100 ms pulse
// (RULE_12) dual topology pairs master pin3, slave pin4
// (RULE_13) static modes unchanged by safe or sleep
// (RULE_14) pins 3,4 safe outputs idle outside safe
// (RULE_15) pins 1,2 idle unless alert drive set; code also drives them whenever safe is set, alert drive or not
// (RULE_16) reserved codes act as undriven input
// (RULE_17) readback shows sampled pin level always
// (RULE_18) output mismatch sets contention flag
// (RULE_19) limit reached enters safe monitoring mode
// (RULE_20) valid refresh zeroes violation counter
// (RULE_21) tick is (divider+1) times 256 us
// (RULE_22) one-shot fires once per safe entry
module wsg_top
   import wsg_pkg::*;
#(
   parameter int TICK_CYC  = `WSG_TICK_CYC,
   parameter int PULSE_CYC = `WSG_PULSE_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sleep_mode,
   input  wire logic [3:0]  pin_in,
   output      logic [3:0]  pin_out,
   output      logic [3:0]  pin_oe,
   output      logic        alert_n
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] k);
      lfsr_next = {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   function automatic logic mode_ok(input int pin, input logic [2:0] m);
      if (pin < 2) begin
         mode_ok = !(m inside {WSG_PIN_SHOT_HI, WSG_PIN_SHOT_LO, WSG_PIN_SLAVE_IN});  // RULE_10
      end else if (pin == 2) begin
         mode_ok = (m != WSG_PIN_SLAVE_IN);
      end else begin
         mode_ok = 1'b1;
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0]   ctrl, wdcfg, next_ctrl, next_wdcfg;
   logic [2:0]    pin_mode [4];
   logic [2:0]    next_pin_mode [4];
   logic [7:0]    key, next_key;
   logic [7:0]    viol_cnt, next_viol_cnt;
   logic [15:0]   win_cnt, next_win_cnt;
   wsg_wd_state_t wd_st, next_wd_st;
   logic          f_exp, f_lim, f_key, f_early, f_alert, safe, safe_q;
   logic          next_f_exp, next_f_lim, next_f_key, next_f_early, next_f_alert, next_safe;
   logic [3:0]    pin_rd, pin_err, next_pin_err;
   logic [21:0]   shot_cnt [2];
   logic [21:0]   next_shot_cnt [2];
   logic [3:0]    next_pin_out, next_pin_oe;

   logic          aw_got, w_got, next_aw_got, next_w_got;
   logic [7:0]    wa, next_wa;
   logic [31:0]   wd, next_wd;
   logic [3:0]    ws, next_ws;
   logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]    next_bresp, next_rresp;
   logic [31:0]   next_rdata;

   logic          wr_go, key_wr, wr_hit, rd_hit;
   logic [15:0]   closed_len, open_len, first_len;
   logic [31:0]   rd_val;

   wsg_tick_if tk ();

   wsg_ticker #(.TICK_CYC(TICK_CYC)) i_wsg_ticker (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tk      (tk)
   );

   assign tk.run          = (wd_st != WSG_WD_OFF);
   assign tk.tick_divider = wdcfg[`WSG_CFG_DIV_LSB +: 5];

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   assign wr_go  = aw_got && w_got && !s_axi_bvalid;
   assign key_wr = wr_go && (wa == `WSG_ADR_KEY);
   assign wr_hit = (wa == `WSG_ADR_CTRL) || (wa == `WSG_ADR_WDCFG) || (wa == `WSG_ADR_KEY)
                   || (wa == `WSG_ADR_ALERT) || (wa >= `WSG_ADR_PIN1 && wa <= `WSG_ADR_PIN4
                   && wa[1:0] == 2'b00);

   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `WSG_ADR_CTRL:    rd_val = ctrl;
         `WSG_ADR_WDCFG:   rd_val = wdcfg;
         `WSG_ADR_KEY:     rd_val = {24'h00_0000, key};  // RULE_08
         `WSG_ADR_STATUS:  rd_val = {16'h0000, viol_cnt, 3'h0, safe, f_early, f_key, f_lim, f_exp};
         `WSG_ADR_ALERT:   rd_val = {31'h0000_0000, f_alert};
         `WSG_ADR_PINSTAT: rd_val = {24'h00_0000, pin_err, pin_rd};  // RULE_17
         default: begin
            if (s_axi_araddr >= `WSG_ADR_PIN1 && s_axi_araddr <= `WSG_ADR_PIN4
                && s_axi_araddr[1:0] == 2'b00) begin
               rd_val = {29'h0000_0000, pin_mode[s_axi_araddr[3:2] - 2'h1]};
            end else begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   always_comb begin
      next_aw_got  = aw_got;
      next_w_got   = w_got;
      next_wa      = wa;
      next_wd      = wd;
      next_ws      = ws;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_got = 1'b1;
         next_wa     = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_got = 1'b1;
         next_wd    = s_axi_wdata;
         next_ws    = s_axi_wstrb;
      end
      if (wr_go) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = wr_hit ? `WSG_RESP_OKAY : `WSG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_val;
         next_rresp  = rd_hit ? `WSG_RESP_OKAY : `WSG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      // one write and one read in flight; a channel reopens once its answer is taken
      next_awready = !next_aw_got && !next_bvalid;
      next_wready  = !next_w_got && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         wa            <= 8'h00;
         wd            <= 32'h0000_0000;
         ws            <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         aw_got        <= next_aw_got;
         w_got         <= next_w_got;
         wa            <= next_wa;
         wd            <= next_wd;
         ws            <= next_ws;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // watchdog, flags, safe monitoring, pins
   // ------------------------------------------------------------
   assign closed_len = {8'h00, 4'h0, wdcfg[`WSG_CFG_OPEN_LSB +: 4]} + 16'h0001;
   assign open_len   = {8'h00, 4'h0, wdcfg[`WSG_CFG_CLOSED_LSB +: 4]} + 16'h0001;
   assign first_len  = 16'((closed_len + open_len) * 16'd8
                       * ({13'h0000, wdcfg[`WSG_CFG_EXT_LSB +: 3]} + 16'h0002));

   always_comb begin
      logic        en, refresh, timeout, slave_req, act, drv;
      logic [2:0]  m;
      next_ctrl     = ctrl;
      next_wdcfg    = wdcfg;
      next_pin_mode = pin_mode;
      next_key      = key;
      next_viol_cnt = viol_cnt;
      next_win_cnt  = win_cnt;
      next_wd_st    = wd_st;
      next_f_exp    = f_exp;
      next_f_lim    = f_lim;
      next_f_key    = f_key;
      next_f_early  = f_early;
      next_f_alert  = f_alert;
      next_safe     = safe;
      next_shot_cnt = shot_cnt;
      next_pin_out  = pin_out;
      next_pin_oe   = pin_oe;
      next_pin_err  = 4'h0;
      en            = 1'b0;
      slave_req     = 1'b0;
      refresh       = 1'b0;
      timeout       = 1'b0;
      act           = 1'b0;
      drv           = 1'b0;
      m             = 3'h0;
      if (wr_go) begin
         case (wa)
            `WSG_ADR_CTRL:  next_ctrl  = merge(ctrl, wd, ws);
            `WSG_ADR_WDCFG: next_wdcfg = merge(wdcfg, wd, ws);
            `WSG_ADR_ALERT: if (ws[0] && !wd[0]) next_f_alert = 1'b0;
            default: begin
               if (wr_hit && wa != `WSG_ADR_KEY && ws[0]) begin
                  next_pin_mode[wa[3:2] - 2'h1] = wd[2:0];
               end
            end
         endcase
      end
      en = next_ctrl[`WSG_CTRL_EN] && !sleep_mode;
      if (key_wr && (wd_st == WSG_WD_FIRST || wd_st == WSG_WD_OPEN)) begin
         if (ctrl[`WSG_CTRL_SWW] || (wd[7:0] == lfsr_next(key))) begin  // RULE_07 RULE_09
            refresh = 1'b1;
         end else begin
            next_f_key = 1'b1;
         end
      end else if (key_wr && wd_st == WSG_WD_CLOSED && !ctrl[`WSG_CTRL_SWW]) begin
         next_f_early = 1'b1;
      end
      if (tk.tick) begin
         next_win_cnt = win_cnt + 16'h0001;
      end
      case (wd_st)
         WSG_WD_OFF: begin
            next_win_cnt = 16'h0000;
            if (en) next_wd_st = WSG_WD_FIRST;
         end
         WSG_WD_FIRST: begin
            if (tk.tick && win_cnt + 16'h0001 >= first_len) timeout = 1'b1;
         end
         WSG_WD_CLOSED: begin
            if (tk.tick && win_cnt + 16'h0001 >= 16'(closed_len * 16'd8)) begin
               next_wd_st   = WSG_WD_OPEN;
               next_win_cnt = 16'h0000;
            end
         end
         WSG_WD_OPEN: begin
            if (tk.tick && win_cnt + 16'h0001 >= 16'(open_len * 16'd8)) timeout = 1'b1;
         end
         default: next_wd_st = WSG_WD_OFF;
      endcase
      if (refresh) begin
         next_key      = lfsr_next(key);
         next_viol_cnt = 8'h00;  // RULE_20
         next_win_cnt  = 16'h0000;
         next_wd_st    = WSG_WD_CLOSED;
         if (safe) begin
            next_safe  = 1'b0;
            next_wd_st = WSG_WD_FIRST;
         end
      end else if (timeout) begin
         next_win_cnt = 16'h0000;
         next_wd_st   = WSG_WD_CLOSED;
         next_f_exp   = 1'b1;  // RULE_02
         if (viol_cnt != 8'hff) next_viol_cnt = viol_cnt + 8'h01;  // RULE_01
         if (next_viol_cnt == wdcfg[`WSG_CFG_LIMIT_LSB +: 8]) begin
            next_f_lim = 1'b1;  // RULE_03
            next_safe  = 1'b1;  // RULE_19
         end
      end
      // the partner's handover line also forces safe monitoring on the slave side
      slave_req = (pin_mode[3] == WSG_PIN_SLAVE_IN) && pin_rd[3];
      if (slave_req) next_safe = 1'b1;  // RULE_12
      if (!en) begin
         // disabling clears the error flags; watchdog cannot hold the part in safe mode
         next_wd_st    = WSG_WD_OFF;
         next_viol_cnt = 8'h00;
         next_f_exp    = 1'b0;
         next_f_lim    = 1'b0;
         next_f_key    = 1'b0;
         next_f_early  = 1'b0;
         if (!slave_req) next_safe = 1'b0;
      end
      if (ctrl[`WSG_CTRL_ALRTEN] && ((next_f_exp && !f_exp) || (next_f_lim && !f_lim)
          || (next_f_key && !f_key) || (next_f_early && !f_early))) begin
         next_f_alert = 1'b1;  // RULE_04 RULE_06
      end
      for (int s = 0; s < 2; s++) begin
         if (!safe || sleep_mode) begin
            // a pulse never outlives safe monitoring nor runs on into sleep
            next_shot_cnt[s] = 22'h00_0000;  // RULE_14
         end else if (!safe_q) begin
            next_shot_cnt[s] = 22'(PULSE_CYC);  // RULE_11 RULE_22
         end else if (shot_cnt[s] != 22'h00_0000) begin
            next_shot_cnt[s] = shot_cnt[s] - 22'h00_0001;
         end
      end
      for (int p = 0; p < 4; p++) begin
         m = pin_mode[p];
         if (p < 2) begin
            act = safe || (ctrl[`WSG_CTRL_C12ALRT] && !sleep_mode && f_alert);  // RULE_15
         end else begin
            act = safe && !sleep_mode;  // RULE_14
         end
         next_pin_oe[p] = mode_ok(p, m) && !(m inside {WSG_PIN_INPUT, WSG_PIN_SLAVE_IN});  // RULE_16
         case (m)
            WSG_PIN_HI:      drv = 1'b1;  // RULE_13
            WSG_PIN_SHOT_HI: drv = (p > 1) && (shot_cnt[p[0]] != 22'h00_0000);
            WSG_PIN_SHOT_LO: drv = !((p > 1) && (shot_cnt[p[0]] != 22'h00_0000));
            WSG_PIN_ACT_HI:  drv = act;
            WSG_PIN_ACT_LO:  drv = !act;
            default:         drv = 1'b0;
         endcase
         next_pin_out[p] = next_pin_oe[p] && drv;
         next_pin_err[p] = pin_oe[p] && (pin_rd[p] != pin_out[p]);  // RULE_18
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl     <= `WSG_CTRL_RST;
         wdcfg    <= `WSG_WDCFG_RST;
         pin_mode <= '{default: 3'h0};
         key      <= `WSG_KEY_RST;
         viol_cnt <= 8'h00;
         win_cnt  <= 16'h0000;
         wd_st    <= WSG_WD_OFF;
         f_exp    <= 1'b0;
         f_lim    <= 1'b0;
         f_key    <= 1'b0;
         f_early  <= 1'b0;
         f_alert  <= 1'b0;
         safe     <= 1'b0;
         safe_q   <= 1'b0;
         shot_cnt <= '{default: 22'h00_0000};
         pin_rd   <= 4'h0;
         pin_err  <= 4'h0;
         pin_out  <= 4'h0;
         pin_oe   <= 4'h0;
         alert_n  <= 1'b1;
      end else begin
         ctrl     <= next_ctrl;
         wdcfg    <= next_wdcfg;
         pin_mode <= next_pin_mode;
         key      <= next_key;
         viol_cnt <= next_viol_cnt;
         win_cnt  <= next_win_cnt;
         wd_st    <= next_wd_st;
         f_exp    <= next_f_exp;
         f_lim    <= next_f_lim;
         f_key    <= next_f_key;
         f_early  <= next_f_early;
         f_alert  <= next_f_alert;
         safe     <= next_safe;
         safe_q   <= safe;
         shot_cnt <= next_shot_cnt;
         pin_rd   <= pin_in;  // RULE_17
         pin_err  <= next_pin_err;
         pin_out  <= next_pin_out;
         pin_oe   <= next_pin_oe;
         alert_n  <= !next_f_alert;  // RULE_05
      end
   end

endmodule // wsg_top

// >>> wsg_pin_model.sv
// far side of the four pins: pull-downs plus optional outside drivers
// assumes pin_out/pin_oe come straight from wsg_top
`timescale 1ns/1ps
module wsg_pin_model (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] ext_lvl,
   input  wire logic [3:0] clash,
   output      logic [3:0] pin_in
);
   // released pins fall to the pull-down unless ext_lvl drives them;
   // clash fights a driven pin to provoke contention
   assign pin_in = (pin_oe & (pin_out ^ clash)) | (~pin_oe & ext_lvl);
endmodule // wsg_pin_model

// >>> wsg_top_sva.sv
// bus and pin timing checks for wsg_top
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module wsg_top_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sleep_mode,
   input wire logic [3:0]  pin_out,
   input wire logic [3:0]  pin_oe,
   input wire logic        alert_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_write_lat; s_both_taken |=> s_resp_late; endproperty
   a_write_lat: assert property (p_write_lat) else $error("write answer late or early");
   property p_read_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer missing");
   property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write answer dropped");
   property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read answer dropped");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
   // interrupt may only release on a completed host write (the flag clear)
   property p_alert_hold; $rose(alert_n) && !$past(rst) |-> $rose(s_axi_bvalid); endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("interrupt released alone");
   property p_sleep_hold;
      (sleep_mode && !s_axi_bvalid) [*3] |=> $stable(pin_out) && $stable(pin_oe);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("pin moved in sleep");
   property p_sleep_quiet; sleep_mode [*3] |=> !$fell(alert_n); endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("watchdog error in sleep");
endmodule // wsg_top_sva

bind wsg_top wsg_top_sva i_wsg_top_sva (.*);

// >>> wsg_top_test.sv
// self-checking bench for wsg_top with shortened tick and pulse counts
// assumes the pin model's pull-downs; TICK_CYC 4, PULSE_CYC 20
`timescale 1ns/1ps
module wsg_top_test;
   import wsg_pkg::*;
   typedef struct packed {logic [7:0] adr; logic [2:0] mode; logic oe; logic lvl;} wsg_row_t;
   logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_mode;
   logic alert_n;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, k;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb, pin_in, pin_out, pin_oe, clash, ext_lvl;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          error_cnt = 0, n_tests = 0, p;
   wsg_row_t    rows [12] = '{'{8'h14,3'd0,1'b0,1'b0}, '{8'h14,3'd1,1'b1,1'b1},
      '{8'h14,3'd2,1'b1,1'b0}, '{8'h14,3'd3,1'b0,1'b0}, '{8'h14,3'd4,1'b0,1'b0},
      '{8'h14,3'd5,1'b1,1'b0}, '{8'h14,3'd6,1'b1,1'b1}, '{8'h14,3'd7,1'b0,1'b0},
      '{8'h1c,3'd3,1'b1,1'b0}, '{8'h1c,3'd4,1'b1,1'b1}, '{8'h1c,3'd7,1'b0,1'b0},
      '{8'h20,3'd7,1'b0,1'b0}};

   wsg_top #(.TICK_CYC(4), .PULSE_CYC(20)) i_wsg_top (.*);
   wsg_pin_model i_wsg_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
                                  .clash(clash), .pin_in(pin_in));

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // -----------------------------------------
   // bus master: hold each channel until taken
   // -----------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0;
   endtask
   task close_out;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard, far beyond the ~600 cycles of the sequence
   initial begin
      repeat (6000) @(posedge clk_sys);
      error_cnt++;
      close_out;
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, clash, ext_lvl, sleep_mode} = '0;
      s_axi_wstrb = 4'hf; rst = 1;
      repeat (10) @(posedge clk_sys);
      rst <= 0;
      rd(8'h00); chk(d, 32'h24);
      rd(8'h04); chk(d, 32'h0001_0000);
      rd(8'h08); chk(d, 32'h5a);
      rd(8'h40); chk(d, 32'h0);
      chk({30'h0, rsp}, 32'h2);
      wr(8'h40, 32'h1); chk({30'h0, rsp}, 32'h2);
      foreach (rows[i]) begin
         p = (rows[i].adr - 8'h14) >> 2;
         wr(rows[i].adr, {29'h0, rows[i].mode});
         repeat (3) @(posedge clk_sys);
         chk({pin_oe[p], pin_out[p] & pin_oe[p]}, {rows[i].oe, rows[i].lvl});
         rd(8'h24); chk({d[p + 4], d[p]}, {1'b0, rows[i].lvl});
      end
      wr(8'h14, 32'h1); wr(8'h18, 32'h5); wr(8'h1c, 32'h4); wr(8'h20, 32'h0);
      clash <= 4'h1;
      repeat (4) @(posedge clk_sys);
      rd(8'h24); chk(d[7:0], 8'h14);
      clash <= 4'h0; sleep_mode <= 1;
      repeat (8) @(posedge clk_sys);
      chk({pin_oe, pin_out & pin_oe}, 8'h75);
      sleep_mode <= 0;
      wr(8'h04, 32'h0002_0000); wr(8'h00, 32'h25);
      wr(8'h08, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(alert_n, 0);
      wr(8'h10, 32'h1); wr(8'h10, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(alert_n, 1);
      k = lfsr(8'h5a);
      wr(8'h08, {24'h0, k});
      rd(8'h08); chk(d, {24'h0, k});
      wr(8'h08, {24'h0, lfsr(k)});
      rd(8'h0c); chk(d[15:0], 16'h000c);
      for (p = 0; p < 1000 && !pin_out[1]; p++) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      chk(pin_out[2], 0);
      rd(8'h0c); chk(d[15:0], 16'h021f);
      repeat (25) @(posedge clk_sys);
      chk(pin_out[2], 1);
      repeat (150) @(posedge clk_sys);
      chk(pin_out[2], 1);
      wr(8'h00, 32'h24);
      rd(8'h0c); chk(d, 0);
      chk({alert_n, pin_out[1]}, 0);
      wr(8'h00, 32'h2c);
      repeat (3) @(posedge clk_sys);
      chk(pin_out[1], 1);
      wr(8'h10, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk(pin_out[1], 0);
      wr(8'h00, 32'h27);
      rd(8'h08); k = d[7:0];
      wr(8'h08, {24'h0, ~lfsr(k)});
      rd(8'h0c); chk(d, 0);
      rd(8'h08); chk(d[7:0], lfsr(k));
      // partner hands control over on pin 4
      wr(8'h20, 32'h7);
      ext_lvl <= 4'h8;
      repeat (3) @(posedge clk_sys);
      rd(8'h0c); chk(d[4], 1);
      // reset in mid-run
      rst <= 1;
      repeat (3) @(posedge clk_sys);
      chk({alert_n, pin_oe, pin_out}, 9'h100);
      rst <= 0;
      rd(8'h00); chk(d, 32'h24);
      close_out;
   end
endmodule // wsg_top_test
